// File: core/gsr_readback.sv
// Status word selection, capture and serial shift-out for a dual gauge driver.
// Assumes motion logic on i_sys_clk supplies live gauge state; serial pins are
// asynchronous and slow enough that each level lasts at least six clocks.
`timescale 1ns/1ps
`include "gsr_consts.svh"

// Function
// - Command bits 11:10 = 10 select the accumulator word.
// - Command bits 11:8 = 1100 select the gauge 0 position word.
// - Command bits 11:8 = 1101 select the gauge 1 position word.
// - Command bits 11:9 = 111 select the combined velocity word.
// - Accumulator bit 15 shows return-to-zero active until message after zero or off.
// - Accumulator bits 14:0 carry the non-driven coil integrator value.
// - Integrator field clears at power-on and reset pin release.
// - Integrator field holds its last value after return-to-zero ends.
// - Integrator value is two's complement with bit 14 as sign.
// - Position word bit 15 shows gauge enabled.
// - Position word bit 14 shows direction relative to position zero.
// - Position word bit 13 shows heading toward or away from target.
// - Position word bit 12 is set when not at commanded position.
// - Position word bits 11:0 hold pointer position at chip select fall.
// - Gauge 1 position word uses the gauge 0 layout.
// - Velocity word bits 15:8 hold gauge 1 velocity index.
// - Velocity word bits 7:0 hold gauge 0 velocity index.
// - Stopped on truncated ramp reports the untruncated index.
// - Status words are read-only; serial data never alters them.
// - Chip select fall loads the selected word, shifted out MSB first.
// - Only non-zero, multiple-of-16 bit messages are accepted.
module gsr_readback
   import gsr_pkg::*;
(
   input  wire logic          i_sys_clk,
   input  wire logic          i_resetn,
   input  wire logic          i_cs_n,
   input  wire logic          i_sclk,
   input  wire logic          i_mosi,
   output logic               o_miso,
   output logic               o_miso_oe,
   output logic [15:0]        o_rx_word,
   output logic               o_rx_valid,
   output logic               o_return_to_zero,
   input  wire logic [15:0]   i_device_status,
   input  wire logic          i_rtz_start,
   input  wire logic          i_rtz_stop,
   input  wire logic          i_zero_detected,
   input  wire logic          i_integrator_valid,
   input  wire logic [14:0]   i_zero_detect_integrator,
   input  wire logic          i_gauge0_enabled_flag,
   input  wire logic          i_gauge0_direction,
   input  wire logic          i_gauge0_heading_vs_target,
   input  wire logic          i_gauge0_not_at_target,
   input  wire logic [11:0]   i_gauge0_pointer_position,
   input  gsr_pkg::gsr_vidx_t i_gauge0_velocity_index,
   input  gsr_pkg::gsr_rs_t   i_gauge0_truncation,
   input  wire logic          i_gauge1_enabled_flag,
   input  wire logic          i_gauge1_direction,
   input  wire logic          i_gauge1_heading_vs_target,
   input  wire logic          i_gauge1_not_at_target,
   input  wire logic [11:0]   i_gauge1_pointer_position,
   input  gsr_pkg::gsr_vidx_t i_gauge1_velocity_index,
   input  gsr_pkg::gsr_rs_t   i_gauge1_truncation
);
   logic        cs_lvl;
   logic        sclk_lvl;
   logic        mosi_lvl;
   logic        cs_prev_q;
   logic        sclk_prev_q;
   logic        cs_fall;
   logic        cs_rise;
   logic        sclk_rise;
   logic        sclk_fall;
   gsr_link_e   link_q;
   gsr_sel_e    sel_q;
   logic [15:0] rx_sr_q;
   logic [15:0] tx_sr_q;
   logic [3:0]  cnt_q;
   logic        any_q;
   logic        msg_ok;
   logic        occ_hit;
   logic        rtz_q;
   logic        zero_seen_q;
   logic [14:0] acc_q;
   gsr_vidx_t   vel0;
   gsr_vidx_t   vel1;
   logic [15:0] word_d;

   gsr_pin_sync #(.RESET_VAL(1'b1)) u_sync_cs (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_pin     (i_cs_n),
      .o_level   (cs_lvl)
   );
   gsr_pin_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_pin     (i_sclk),
      .o_level   (sclk_lvl)
   );
   gsr_pin_sync #(.RESET_VAL(1'b0)) u_sync_mosi (
      .i_sys_clk (i_sys_clk),
      .i_resetn  (i_resetn),
      .i_pin     (i_mosi),
      .o_level   (mosi_lvl)
   );

   gsr_vel_report u_vel0 (
      .i_raw_index  (i_gauge0_velocity_index),
      .i_truncation (i_gauge0_truncation),
      .i_stopped    (!i_gauge0_not_at_target),
      .o_index      (vel0)
   );
   gsr_vel_report u_vel1 (
      .i_raw_index  (i_gauge1_velocity_index),
      .i_truncation (i_gauge1_truncation),
      .i_stopped    (!i_gauge1_not_at_target),
      .o_index      (vel1)
   );

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cs_prev_q   <= 1'b1;
         sclk_prev_q <= 1'b0;
      end else begin
         cs_prev_q   <= cs_lvl;
         sclk_prev_q <= sclk_lvl;
      end
   end

   assign cs_fall   = cs_prev_q && !cs_lvl;
   assign cs_rise   = !cs_prev_q && cs_lvl;
   assign sclk_rise = !sclk_prev_q && sclk_lvl && (link_q == LINK_SHIFT);
   assign sclk_fall = sclk_prev_q && !sclk_lvl && (link_q == LINK_SHIFT);
   assign msg_ok    = any_q && (cnt_q == `GSR_CNT_RESET);
   assign occ_hit   = rx_sr_q[`GSR_OP_HI:`GSR_OP_LO] == `GSR_OCC_OPCODE;

   // Frame sequencing
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         link_q <= LINK_IDLE;
      end else begin
         case (link_q)
            LINK_IDLE:  if (cs_fall) link_q <= LINK_SHIFT;
            LINK_SHIFT: if (cs_rise) link_q <= LINK_CHECK;
            LINK_CHECK: link_q <= LINK_IDLE;
            default:    link_q <= LINK_IDLE;
         endcase
      end
   end

   // Receive shift and bit count; count wraps every 16 bits
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rx_sr_q <= `GSR_RX_RESET;
         cnt_q   <= `GSR_CNT_RESET;
         any_q   <= 1'b0;
      end else if (cs_fall) begin
         cnt_q <= `GSR_CNT_RESET;
         any_q <= 1'b0;
      end else if (sclk_rise) begin
         rx_sr_q <= {rx_sr_q[14:0], mosi_lvl};
         cnt_q   <= cnt_q + 4'h1;
         any_q   <= 1'b1;
      end
   end

   // Accepted word goes out for the rest of the device to latch
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rx_word  <= `GSR_RX_RESET;
         o_rx_valid <= 1'b0;
      end else begin
         o_rx_valid <= (link_q == LINK_CHECK) && msg_ok;
         if ((link_q == LINK_CHECK) && msg_ok) begin
            o_rx_word <= rx_sr_q;
         end
      end
   end

   // Output selection from the last valid configuration command
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sel_q <= SEL_DEVICE;
      end else if ((link_q == LINK_CHECK) && msg_ok && occ_hit) begin
         if (!rx_sr_q[`GSR_SEL_B11]) begin
            sel_q <= SEL_DEVICE;
         end else if (!rx_sr_q[`GSR_SEL_B10]) begin
            sel_q <= SEL_ACCUM;
         end else if (rx_sr_q[`GSR_SEL_B9]) begin
            sel_q <= SEL_VEL;
         end else if (rx_sr_q[`GSR_SEL_B8]) begin
            sel_q <= SEL_POS1;
         end else begin
            sel_q <= SEL_POS0;
         end
      end
   end

   // Return-to-zero flag; a start in the clearing cycle wins
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rtz_q       <= 1'b0;
         zero_seen_q <= 1'b0;
      end else begin
         if (i_rtz_stop || ((link_q == LINK_CHECK) && msg_ok && zero_seen_q)) begin
            rtz_q       <= 1'b0;
            zero_seen_q <= 1'b0;
         end
         if (rtz_q && i_zero_detected) begin
            zero_seen_q <= 1'b1;
         end
         if (i_rtz_start) begin
            rtz_q       <= 1'b1;
            zero_seen_q <= 1'b0;
         end
      end
   end

   // Integrator snapshot, held once the run stops; no serial write path
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         acc_q <= `GSR_ACC_RESET;
      end else if (rtz_q && i_integrator_valid) begin
         acc_q <= i_zero_detect_integrator;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_return_to_zero <= 1'b0;
      end else begin
         o_return_to_zero <= rtz_q;
      end
   end

   // Live word; sampled only at chip select fall
   always_comb begin
      case (sel_q)
         SEL_ACCUM: word_d = {rtz_q, acc_q};
         SEL_POS0:  word_d = {i_gauge0_enabled_flag, i_gauge0_direction,
                             i_gauge0_heading_vs_target, i_gauge0_not_at_target,
                             i_gauge0_pointer_position};
         SEL_POS1:  word_d = {i_gauge1_enabled_flag, i_gauge1_direction,
                             i_gauge1_heading_vs_target, i_gauge1_not_at_target,
                             i_gauge1_pointer_position};
         SEL_VEL:   word_d = {vel1, vel0};
         default:   word_d = i_device_status;
      endcase
   end

   // Transmit: load at frame start, advance on each clock fall
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tx_sr_q <= `GSR_TX_RESET;
      end else if (cs_fall) begin
         tx_sr_q <= word_d;
      end else if (sclk_fall) begin
         tx_sr_q <= {tx_sr_q[14:0], 1'b0};
      end
   end

   assign o_miso = tx_sr_q[`GSR_WORD_BITS-1];

   // Driven only inside a frame so the line is shared
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_miso_oe <= 1'b0;
      end else if (cs_fall) begin
         o_miso_oe <= 1'b1;
      end else if (cs_rise) begin
         o_miso_oe <= 1'b0;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   a_sel_accum: assert property ((link_q == LINK_CHECK) && msg_ok && occ_hit
      && (rx_sr_q[11:10] == 2'b10) |=> (sel_q == SEL_ACCUM))
      else $error("accumulator word not selected");
   a_sel_pos_zero: assert property ((link_q == LINK_CHECK) && msg_ok && occ_hit
      && (rx_sr_q[11:8] == 4'hc) |=> (sel_q == SEL_POS0))
      else $error("gauge 0 position word not selected");
   a_sel_pos_one: assert property ((link_q == LINK_CHECK) && msg_ok && occ_hit
      && (rx_sr_q[11:8] == 4'hd) |=> (sel_q == SEL_POS1))
      else $error("gauge 1 position word not selected");
   a_sel_vel: assert property ((link_q == LINK_CHECK) && msg_ok && occ_hit
      && (rx_sr_q[11:9] == 3'h7) |=> (sel_q == SEL_VEL))
      else $error("velocity word not selected");
   a_rtz_off: assert property (i_rtz_stop && !i_rtz_start |=> !rtz_q ##1
      (o_return_to_zero == 1'b0))
      else $error("return-to-zero flag not cleared by stop");
   a_acc_hold: assert property (!rtz_q |=> $stable(acc_q))
      else $error("integrator changed outside a run");
   a_pos_capture: assert property (cs_fall && (sel_q == SEL_POS0) |=>
      (tx_sr_q[11:0] == $past(i_gauge0_pointer_position))
      && (tx_sr_q[15] == $past(i_gauge0_enabled_flag)))
      else $error("position word not captured at select fall");
   a_vel_untrunc: assert property (cs_fall && (sel_q == SEL_VEL)
      && !i_gauge0_not_at_target && (i_gauge0_truncation == 3'h2)
      |=> (tx_sr_q[7:0] == 8'h03))
      else $error("stopped truncated index wrong");
   a_msb_first: assert property (sclk_fall |=>
      (o_miso == $past(tx_sr_q[14])) && (tx_sr_q[0] == 1'b0))
      else $error("shift order wrong");
   a_frame_len: assert property ((link_q == LINK_CHECK) && !msg_ok |=>
      !o_rx_valid ##1 !o_rx_valid)
      else $error("bad length frame accepted");
   a_oe_frame: assert property (cs_fall |=> o_miso_oe [*2])
      else $error("output not driven in frame");

   c_accum_read: cover property (cs_fall && (sel_q == SEL_ACCUM));
   c_valid_frame: cover property ((link_q == LINK_CHECK) && msg_ok && occ_hit);
   c_zero_clear: cover property (zero_seen_q && (link_q == LINK_CHECK) && msg_ok);
   c_bad_frame: cover property ((link_q == LINK_CHECK) && any_q && !msg_ok);
endmodule : gsr_readback

// File: core/gsr_consts.svh
// Constants for the gauge status readback block.
// Assumes inclusion by bare name from the core design files.
`ifndef GSR_CONSTS_SVH
`define GSR_CONSTS_SVH

`define GSR_WORD_BITS     16
`define GSR_OP_HI         15
`define GSR_OP_LO         12
`define GSR_OCC_OPCODE    4'h9
`define GSR_SEL_B11       11
`define GSR_SEL_B10       10
`define GSR_SEL_B9        9
`define GSR_SEL_B8        8
`define GSR_ACC_FLAG_BIT  15
`define GSR_ACC_SIGN_BIT  14
`define GSR_ACC_RESET     15'h0000
`define GSR_TX_RESET      16'h0000
`define GSR_RX_RESET      16'h0000
`define GSR_CNT_RESET     4'h0

`endif

// File: core/gsr_pkg.sv
// Types shared by the gauge status readback block.
// Assumes gsr_consts.svh supplies the numeric constants.
package gsr_pkg;
   typedef logic [2:0] gsr_rs_t;
   typedef logic [7:0] gsr_vidx_t;
   typedef enum logic [2:0] {
      SEL_DEVICE = 3'h0,
      SEL_ACCUM  = 3'h1,
      SEL_POS0   = 3'h2,
      SEL_POS1   = 3'h3,
      SEL_VEL    = 3'h4
   } gsr_sel_e;
   typedef enum logic [1:0] {
      LINK_IDLE  = 2'b00,
      LINK_SHIFT = 2'b01,
      LINK_CHECK = 2'b11
   } gsr_link_e;
endpackage : gsr_pkg

// File: core/gsr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous pin; output changes once stages two and three agree.
`timescale 1ns/1ps
module gsr_pin_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic i_sys_clk,
   input  wire logic i_resetn,
   input  wire logic i_pin,
   output logic      o_level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
      end else begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Filter reads only stages two and three
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_level <= RESET_VAL;
      end else if (s2_q == s3_q) begin
         o_level <= s3_q;
      end
   end
endmodule : gsr_pin_sync

// File: core/gsr_vel_report.sv
// Velocity index as reported: untruncated index once the pointer rests.
// Assumes the ramp logic gives its truncated index and truncation setting.
`timescale 1ns/1ps
module gsr_vel_report
   import gsr_pkg::*;
(
   input  gsr_pkg::gsr_vidx_t i_raw_index,
   input  gsr_pkg::gsr_rs_t   i_truncation,
   input  wire logic          i_stopped,
   output gsr_pkg::gsr_vidx_t o_index
);
   // Stopped on a truncated ramp reads one past the setting
   always_comb begin
      if (i_stopped && (i_truncation != 3'h0)) begin
         o_index = {5'h00, i_truncation} + 8'h01;
      end else begin
         o_index = i_raw_index;
      end
   end
endmodule : gsr_vel_report

// File: test/gsr_spi_master.sv
// SPI master model reading gauge status words.
// Assumes the block synchronises the pins to i_sys_clk; levels last 8 clocks.
`timescale 1ns/1ps
module gsr_spi_master (
   input  wire logic i_sys_clk,
   input  wire logic i_miso,
   output logic      o_cs_n,
   output logic      o_sclk,
   output logic      o_mosi
);
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_mosi = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask : hold

   // Caller picks the length; odd lengths exist only to provoke refusal
   task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
      rx = '0;
      o_cs_n <= 1'b0;
      for (int i = nbits - 1; i >= 0; i--) begin
         o_mosi <= tx[i];
         hold(8);
         o_sclk <= 1'b1;
         rx = {rx[30:0], i_miso};
         hold(8);
         o_sclk <= 1'b0;
      end
      hold(8);
      o_cs_n <= 1'b1;
      // Released line must not keep its last value
      o_mosi <= ~o_mosi;
      hold(12);
   endtask : xfer
endmodule : gsr_spi_master

// File: test/tb.sv
// Self-checking bench for the gauge status readback block.
// Assumes the SPI master model drives the serial pins.
`timescale 1ns/1ps
module tb;
   import gsr_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cs_n, sclk, mosi, miso, oe, rx_valid, return_to_zero;
   logic [15:0] rx_word;
   logic [15:0] dev = 16'hc3a5;
   logic [3:0]  ctl = 4'h0;
   logic [14:0] integ = 15'h0000;
   logic [3:0]  g0f = 4'h0, g1f = 4'h0;
   logic [11:0] pos0 = 12'h000, pos1 = 12'h000;
   gsr_vidx_t   vi0 = 8'h00, vi1 = 8'h00;
   gsr_rs_t     tr0 = 3'h0, tr1 = 3'h0;
   logic [31:0] got;
   int          miscompares = 0;
   int          tests_run = 0;
   int          pulses = 0;

   always #20 clk = ~clk;
   always @(posedge clk) if (rx_valid === 1'b1) pulses <= pulses + 1;

   gsr_spi_master master (.i_sys_clk(clk), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_mosi(mosi));

   gsr_readback DUT (.i_sys_clk(clk), .i_resetn(rst_n), .i_cs_n(cs_n), .i_sclk(sclk),
      .i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe), .o_rx_word(rx_word),
      .o_rx_valid(rx_valid), .o_return_to_zero(return_to_zero), .i_device_status(dev),
      .i_rtz_start(ctl[3]), .i_rtz_stop(ctl[2]), .i_zero_detected(ctl[1]),
      .i_integrator_valid(ctl[0]), .i_zero_detect_integrator(integ),
      .i_gauge0_enabled_flag(g0f[3]), .i_gauge0_direction(g0f[2]),
      .i_gauge0_heading_vs_target(g0f[1]), .i_gauge0_not_at_target(g0f[0]),
      .i_gauge0_pointer_position(pos0), .i_gauge0_velocity_index(vi0),
      .i_gauge0_truncation(tr0), .i_gauge1_enabled_flag(g1f[3]),
      .i_gauge1_direction(g1f[2]), .i_gauge1_heading_vs_target(g1f[1]),
      .i_gauge1_not_at_target(g1f[0]), .i_gauge1_pointer_position(pos1),
      .i_gauge1_velocity_index(vi1), .i_gauge1_truncation(tr1));

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic pulse(input logic [3:0] m);
      ctl <= m;
      tick(1);
      ctl <= 4'h0;
      tick(2);
   endtask : pulse

   // Opcode nibble zero keeps the selection as it is
   task automatic rd;
      master.xfer(32'h0, 16, got);
   endtask : rd

   task automatic sel(input logic [15:0] c);
      master.xfer({16'h0, c}, 16, got);
   endtask : sel

   task automatic t_reset;
      check({13'h0, oe, rx_valid, return_to_zero}, 16'h0000);
      check(rx_word, 16'h0000);
      rd;
      check(got[15:0], 16'hc3a5);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_accum;
      pulse(4'h8);
      integ <= 15'h4a5c;
      pulse(4'h1);
      check({15'h0, return_to_zero}, 16'h0001);
      sel(16'h9b00);
      rd;
      check(got[15:0], 16'hca5c);
      pulse(4'h4);
      integ <= 15'h1111;
      pulse(4'h1);
      check({15'h0, return_to_zero}, 16'h0000);
      rd;
      check(got[15:0], 16'h4a5c);
      pulse(4'h8);
      pulse(4'h2);
      rd;
      check(got[15:0] & 16'h8000, 16'h8000);
      rd;
      check(got[15:0] & 16'h8000, 16'h0000);
      // Start and stop together: start wins
      pulse(4'hc);
      check({15'h0, return_to_zero}, 16'h0001);
      pulse(4'h4);
      check({15'h0, return_to_zero}, 16'h0000);
      $display("t_accum done");
   endtask : t_accum

   task automatic t_pos;
      g0f <= 4'b1010;
      pos0 <= 12'h5a3;
      g1f <= 4'b0101;
      pos1 <= 12'ha5c;
      sel(16'h9c00);
      fork
         rd;
         begin
            tick(30);
            pos0 <= 12'h111;
            check({15'h0, oe}, 16'h0001);
         end
      join
      check(got[15:0], 16'ha5a3);
      check({15'h0, oe}, 16'h0000);
      sel(16'h9d00);
      rd;
      check(got[15:0], 16'h5a5c);
      $display("t_pos done");
   endtask : t_pos

   task automatic t_vel;
      vi1 <= 8'ha5;
      tr1 <= 3'h2;
      vi0 <= 8'h10;
      tr0 <= 3'h2;
      sel(16'h9e00);
      rd;
      check(got[15:0], 16'ha503);
      sel(16'h9f00);
      rd;
      check(got[15:0], 16'ha503);
      // Gauge 1 stopped on its truncated ramp, gauge 0 untruncated
      g1f <= 4'b0100;
      tr0 <= 3'h0;
      rd;
      check(got[15:0], 16'h0310);
      $display("t_vel done");
   endtask : t_vel

   task automatic t_length;
      int p;
      p = pulses;
      master.xfer(32'h0, 0, got);
      master.xfer(32'h9c, 8, got);
      check(16'(pulses - p), 16'h0000);
      rd;
      check(got[15:0], 16'h0310);
      p = pulses;
      master.xfer(32'h98009c00, 32, got);
      check(rx_word, 16'h9c00);
      check(16'(pulses - p), 16'h0001);
      master.xfer(32'hffff, 16, got);
      rd;
      check(got[15:0], 16'ha111);
      $display("t_length done");
   endtask : t_length

   task automatic t_rst2;
      pulse(4'h8);
      rst_n <= 1'b0;
      tick(3);
      rst_n <= 1'b1;
      tick(2);
      check({13'h0, oe, rx_valid, return_to_zero}, 16'h0000);
      sel(16'h9800);
      rd;
      check(got[15:0], 16'h0000);
      // Bit 11 clear falls back to the device word
      sel(16'h9700);
      rd;
      check(got[15:0], 16'hc3a5);
      $display("t_rst2 done");
   endtask : t_rst2

   task automatic complete_run;
      $display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run

   initial begin
      tick(3);
      rst_n <= 1'b1;
      tick(2);
      t_reset;
      t_accum;
      t_pos;
      t_vel;
      t_length;
      t_rst2;
      complete_run;
   end

   // Hang guard; the whole run needs well under this many clocks
   initial begin
      tick(60000);
      miscompares++;
      complete_run;
   end
endmodule : tb
